/* logic/jecb_pkg.sv */
// Purpose: Constants for the engine-conditions broadcast framer
// Assumes: 20 MHz core clock, raw measurements already in frame scaling
// Notes:   Identifier fields, periods and byte fills for seven frames
package jecb_pkg;

   localparam int          CLK_HZ         = 20_000_000;
   localparam int          TICK_US        = 1000;
   localparam int          TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
   localparam int          N_FRAMES       = 7;

   // Periods in milliseconds
   localparam logic [9:0]  PER_FUEL_MS    = 10'd100;
   localparam logic [9:0]  PER_AMB_MS     = 10'd1000;
   localparam logic [9:0]  PER_INEX_MS    = 10'd500;
   localparam logic [9:0]  PER_PORT_MS    = 10'd1000;

   // Identifier fields
   localparam logic [2:0]  PRIO_STD       = 3'h6;
   localparam logic [2:0]  PRIO_PORT      = 3'h7;
   localparam logic        DATA_PAGE      = 1'b0;
   localparam logic [7:0]  PDU_FMT        = 8'hFE;
   localparam logic [7:0]  PS_FUEL        = 8'hF2;
   localparam logic [7:0]  PS_AMB         = 8'hF5;
   localparam logic [7:0]  PS_INEX        = 8'hF6;
   localparam logic [7:0]  PS_PORT_1_4    = 8'hA3;
   localparam logic [7:0]  PS_PORT_5_8    = 8'hA2;
   localparam logic [7:0]  PS_PORT_9_12   = 8'hA1;
   localparam logic [7:0]  PS_PORT_13_16  = 8'hA0;
   localparam logic [3:0]  DATA_LEN       = 4'h8;

   // Fill and limits
   localparam logic [7:0]  FILL_BYTE      = 8'hFF;
   localparam logic [15:0] FUEL_ECON_MAX  = 16'hFB00;

   typedef enum logic [2:0] {
      FR_FUEL, FR_AMB, FR_INEX, FR_P1, FR_P2, FR_P3, FR_P4
   } jecb_frame_t;

endpackage

/* logic/jecb_sched_if.sv */
// Purpose: Carries sticky frame-pending bits from scheduler to framer
// Assumes: Single core clock
// Notes:   Pending bits stay high until the framer acknowledges
`timescale 1ns/1ps
interface jecb_sched_if;
   logic [6:0] pend;
   logic [6:0] ack;
   modport sched (output pend, input ack);
   modport framer (input pend, output ack);
endinterface

/* logic/jecb_sched.sv */
// Purpose: Millisecond scheduler with sticky per-frame pending bits
// Assumes: Single core clock, asynchronous active-low reset
// Notes:   A late frame stays pending rather than being dropped
`timescale 1ns/1ps
module jecb_sched
   import jecb_pkg::*;
#(
   // Core cycles per scheduler tick; a bench may shorten it
   parameter int TICK_CYCLES = TICK_CYC
)
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   jecb_sched_if.sched     sif
);

   localparam logic [9:0] PERIOD [N_FRAMES] = '{
      PER_FUEL_MS, PER_AMB_MS, PER_INEX_MS,
      PER_PORT_MS, PER_PORT_MS, PER_PORT_MS, PER_PORT_MS};

   logic [14:0] div_cnt;
   logic        ms_tick;
   wire         div_end = (div_cnt == 15'(TICK_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////
   // millisecond tick
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_cnt <= '0;
         ms_tick <= 1'b0;
      end
      else
      begin
         div_cnt <= div_end ? '0 : div_cnt + 15'h1;
         ms_tick <= div_end;
      end
   end

   ////////////////////////////////////////////////////////////////////
   wire [N_FRAMES-1:0] due;
   genvar g;
   generate
      for (g = 0; g < N_FRAMES; g++)
      begin : g_frame
         logic [9:0] ms_cnt;
         assign due[g] = ms_tick && (ms_cnt == PERIOD[g] - 10'h1);
         always_ff @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
               ms_cnt <= '0;
            else if (ms_tick)
               ms_cnt <= due[g] ? '0 : ms_cnt + 10'h1;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // set beats ack
   // One process owns the whole pending word
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         sif.pend <= '0;
      else
         sif.pend <= due | (sif.pend & ~sif.ack);
   end

endmodule // jecb_sched

/* logic/jecb_broadcast.sv */
// Purpose: Packs engine measurements into 8-byte broadcast frames
// Assumes: Inputs already in wire scaling; transmit path on core_clk
// Notes:   One frame is offered at a time with valid/ready handshake
//
// Operation
// - Fuel economy frame every 100 ms, PGN 00FEF2, prio 6, fuel rate 1-2.
// - Instant and average fuel economy in bytes 3-4 and 5-6, capped at 125.5 km/L, 7-8 fill.
// - Ambient frame every 1 s, PGN 00FEF5, prio 6, baro pressure byte 1.
// - Ambient air temperature bytes 4-5, air inlet temperature byte 6.
// - Cab interior byte 2 and road surface bytes 7-8 carry no measurement.
// - Inlet/exhaust frame every 0.5 s, PGN 00FEF6, boost byte 2, inlet pressure byte 4.
// - Intake manifold temperature byte 3, air filter delta pressure byte 5.
// - Exhaust gas temperature bytes 6-7; bytes 1 and 8 unsupported.
// - Ports 1-4 frame every 1 s, prio 7, PS 163, PGN 00FEA3.
// - Ports 5-8 frame every 1 s, prio 7, PGN 00FEA2, PS taken as 162.
// - Ports 9-12 frame every 1 s, prio 7, PGN 00FEA1, PS taken as 161.
// - Ports 13-16 frame every 1 s, prio 7, PS 160, PGN 00FEA0.
// - Each port temperature is a 16-bit 0.03125 C count, -273 C offset.
`timescale 1ns/1ps
module jecb_broadcast
   import jecb_pkg::*;
#(
   // Core cycles per scheduler tick
   parameter int TICK_CYCLES = TICK_CYC
)
(
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic [15:0]  fuel_rate,
   input  wire logic [15:0]  fuel_econ_inst,
   input  wire logic [15:0]  fuel_econ_avg,
   input  wire logic [7:0]   baro_press,
   input  wire logic [15:0]  amb_air_temp,
   input  wire logic [7:0]   air_inlet_temp,
   input  wire logic [7:0]   boost_press,
   input  wire logic [7:0]   manifold_temp,
   input  wire logic [7:0]   air_inlet_press,
   input  wire logic [7:0]   filter_dpress,
   input  wire logic [15:0]  exh_gas_temp,
   input  wire logic [255:0] port_temp,
   output logic              tx_valid,
   input  wire logic         tx_ready,
   output logic [2:0]        tx_prio,
   output logic              tx_dp,
   output logic [7:0]        tx_pf,
   output logic [7:0]        tx_ps,
   output logic [3:0]        tx_dlc,
   output logic [63:0]       tx_data,
   output logic [6:0]        tx_pending
);

   jecb_sched_if sif ();

   ////////////////////////////////////////////////////////////////////
   // Scheduler
   // periodic queueing
   jecb_sched #(.TICK_CYCLES (TICK_CYCLES)) u_sched (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .sif      (sif)
   );

   ////////////////////////////////////////////////////////////////////
   // Field shaping
   // economy cap
   wire [15:0] econ_inst_c = (fuel_econ_inst > FUEL_ECON_MAX) ?
                             FUEL_ECON_MAX : fuel_econ_inst;
   wire [15:0] econ_avg_c  = (fuel_econ_avg > FUEL_ECON_MAX) ?
                             FUEL_ECON_MAX : fuel_econ_avg;

   // Byte 1 sits in data[7:0]; low byte first on multi-byte fields
   // fuel rate placement
   wire [63:0] d_fuel = {FILL_BYTE, FILL_BYTE, econ_avg_c[15:8],
                         econ_avg_c[7:0], econ_inst_c[15:8],
                         econ_inst_c[7:0], fuel_rate[15:8],
                         fuel_rate[7:0]};
   // unsupported filled; byte 3 undefined, also filled
   wire [63:0] d_amb  = {FILL_BYTE, FILL_BYTE, air_inlet_temp,
                         amb_air_temp[15:8], amb_air_temp[7:0],
                         FILL_BYTE, FILL_BYTE, baro_press};
   wire [63:0] d_inex = {FILL_BYTE, exh_gas_temp[15:8],
                         exh_gas_temp[7:0], filter_dpress,
                         air_inlet_press, manifold_temp,
                         boost_press, FILL_BYTE};

   // port fields are 16-bit, passed unchanged low byte first
   wire [63:0] d_port [4];
   genvar gp;
   generate
      for (gp = 0; gp < 4; gp++)
      begin : g_port
         assign d_port[gp] = port_temp[gp*64 +: 64];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Selection: lowest index wins, fuel economy has the shortest period
   logic [2:0] pick;
   wire        any_pend = |sif.pend;
   always_comb
   begin
      pick = 3'h0;
      for (int i = N_FRAMES - 1; i >= 0; i--)
         if (sif.pend[i])
            pick = 3'(i);
   end

   wire        take   = any_pend && (!tx_valid || tx_ready);
   wire        handed = tx_valid && tx_ready;
   logic [2:0] next_prio;
   logic [7:0] next_ps;
   logic [63:0] next_data;

   always_comb
   begin
      next_prio = PRIO_PORT;
      next_ps   = PS_PORT_1_4;
      next_data = d_port[0];
      unique case (jecb_frame_t'(pick))
         FR_FUEL:
         begin
            next_prio = PRIO_STD;
            next_ps   = PS_FUEL;
            next_data = d_fuel;
         end
         FR_AMB:
         begin
            next_prio = PRIO_STD;
            next_ps   = PS_AMB;
            next_data = d_amb;
         end
         FR_INEX:
         begin
            next_prio = PRIO_STD;
            next_ps   = PS_INEX;
            next_data = d_inex;
         end
         FR_P1:
         begin
            next_ps   = PS_PORT_1_4;
            next_data = d_port[0];
         end
         FR_P2:
         begin
            next_ps   = PS_PORT_5_8;
            next_data = d_port[1];
         end
         FR_P3:
         begin
            next_ps   = PS_PORT_9_12;
            next_data = d_port[2];
         end
         FR_P4:
         begin
            next_ps   = PS_PORT_13_16;
            next_data = d_port[3];
         end
         default:
         begin
            next_ps   = PS_PORT_1_4;
         end
      endcase
   end

   // Ack clears the pending bit when the frame is latched
   assign sif.ack = take ? 7'(7'h1 << pick) : 7'h0;

   ////////////////////////////////////////////////////////////////////
   // Output frame register; contents hold steady while valid waits
   // hold until accepted
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_valid   <= 1'b0;
         tx_prio    <= PRIO_STD;
         tx_dp      <= DATA_PAGE;
         tx_pf      <= PDU_FMT;
         tx_ps      <= PS_FUEL;
         tx_dlc     <= DATA_LEN;
         tx_data    <= '1;
         tx_pending <= '0;
      end
      else
      begin
         tx_pending <= sif.pend;
         if (take)
         begin
            tx_valid <= 1'b1;
            tx_prio  <= next_prio;
            tx_ps    <= next_ps;
            tx_data  <= next_data;
            tx_dp    <= DATA_PAGE;
            tx_pf    <= PDU_FMT;
            tx_dlc   <= DATA_LEN;
         end
         else if (handed)
            tx_valid <= 1'b0;
      end
   end

endmodule // jecb_broadcast

/* sim/jecb_broadcast_props.sv */
// Purpose: Assertions on the framer transmit port
// Assumes: One core clock, async active-low reset
// Notes:   Bound to every framer instance
`timescale 1ns/1ps
module jecb_broadcast_props
   import jecb_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic [2:0]  tx_prio,
   input wire logic        tx_dp,
   input wire logic [7:0]  tx_pf,
   input wire logic [7:0]  tx_ps,
   input wire logic [3:0]  tx_dlc,
   input wire logic [63:0] tx_data
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire stall = tx_valid && !tx_ready;
   wire fuel = tx_valid && tx_ps == PS_FUEL;
   ////////////////////////////////////////////////////////////////////////
   property p_hold; stall |=> tx_valid; endproperty
   a_hold: assert property (p_hold) else $error("frame dropped");
   property p_still; stall |=> $stable(tx_data) && $stable(tx_ps); endproperty
   a_still: assert property (p_still) else $error("frame moved");
   property p_id; tx_valid |-> {tx_dp, tx_pf, tx_dlc} == 13'h0FE8; endproperty
   a_id: assert property (p_id) else $error("bad id fields");
   property p_fuel; fuel |-> tx_prio == 3'h6 && tx_data[63:48] == 16'hFFFF;
   endproperty
   a_fuel: assert property (p_fuel) else $error("fuel frame bad");
   property p_cap; fuel |-> tx_data[31:16] <= 16'hFB00
      && tx_data[47:32] <= 16'hFB00; endproperty
   a_cap: assert property (p_cap) else $error("economy over cap");
   property p_amb; tx_valid && tx_ps == PS_AMB |-> tx_data[15:8] == 8'hFF
      && tx_data[63:48] == 16'hFFFF; endproperty
   a_amb: assert property (p_amb) else $error("ambient fill bad");
   property p_inex; tx_valid && tx_ps == PS_INEX |-> tx_data[7:0] == 8'hFF
      && tx_data[63:56] == 8'hFF; endproperty
   a_inex: assert property (p_inex) else $error("inlet fill bad");
   property p_port; tx_valid && tx_ps[7:2] == 6'h28 |-> tx_prio == 3'h7;
   endproperty
   a_port: assert property (p_port) else $error("port prio bad");
endmodule // jecb_broadcast_props
bind jecb_broadcast jecb_broadcast_props u_props (.core_clk(core_clk),
   .rst_n(rst_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .tx_prio(tx_prio), .tx_dp(tx_dp), .tx_pf(tx_pf), .tx_ps(tx_ps),
   .tx_dlc(tx_dlc), .tx_data(tx_data));

/* sim/jecb_tx_sink.sv */
// Purpose: Transmit path stand-in
// Assumes: Same core clock as the framer
// Notes:   Random stalls make due frames pile up
`timescale 1ns/1ps
module jecb_tx_sink
(
   input  wire logic core_clk,
   input  wire logic rst_n,
   output logic      tx_ready
);
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n)
         tx_ready <= 1'b0;
      else
         tx_ready <= ($urandom_range(3) != 0);
endmodule // jecb_tx_sink

/* sim/test_j1939_engine_conditions_broadcast.sv */
// Purpose: Frame contents, order and pending checks
// Assumes: Scheduler tick cut to 10 cycles; period ratios are kept
// Notes:   Inputs change only 50 ms away from any expiry
`timescale 1ns/1ps
module test_j1939_engine_conditions_broadcast;
   import jecb_pkg::*;
   logic core_clk = 0, rst_n = 0, tx_ready, tx_valid, tx_dp;
   logic [15:0] fuel_rate = 0, fuel_econ_inst = 0, fuel_econ_avg = 0;
   logic [15:0] amb_air_temp = 0, exh_gas_temp = 0;
   logic [7:0] baro_press = 0, air_inlet_temp = 0, boost_press = 0;
   logic [7:0] manifold_temp = 0, air_inlet_press = 0, filter_dpress = 0;
   logic [255:0] port_temp = 0;
   logic [2:0] tx_prio;
   logic [7:0] tx_pf, tx_ps;
   logic [3:0] tx_dlc;
   logic [63:0] tx_data;
   logic [6:0] tx_pending;
   logic [74:0] exp_q[$];
   logic [74:0] e;
   int errors = 0, compares = 0, cycles = 0;
   // Short tick so a full second of frames fits a short run
   localparam int TK = 10;
   localparam int PER = int'(PER_FUEL_MS) * TK;
   localparam int HALF = PER / 2;
   localparam int LIMIT = 12 + HALF + 11 * PER;
   localparam logic [12:0] ID_EXP = {DATA_PAGE, PDU_FMT, DATA_LEN};
   logic [6:0] m;
   always #25 core_clk = ~core_clk;
   jecb_broadcast #(.TICK_CYCLES(TK)) dut (.core_clk(core_clk), .rst_n(rst_n),
      .fuel_rate(fuel_rate), .fuel_econ_inst(fuel_econ_inst),
      .fuel_econ_avg(fuel_econ_avg), .baro_press(baro_press),
      .amb_air_temp(amb_air_temp), .air_inlet_temp(air_inlet_temp),
      .boost_press(boost_press), .manifold_temp(manifold_temp),
      .air_inlet_press(air_inlet_press), .filter_dpress(filter_dpress),
      .exh_gas_temp(exh_gas_temp), .port_temp(port_temp),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_prio(tx_prio),
      .tx_dp(tx_dp), .tx_pf(tx_pf), .tx_ps(tx_ps), .tx_dlc(tx_dlc),
      .tx_data(tx_data), .tx_pending(tx_pending));
   jecb_tx_sink u_sink (.core_clk(core_clk), .rst_n(rst_n),
      .tx_ready(tx_ready));
   ///////////////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [63:0] x, logic [63:0] g);
      compares++;
      if (g !== x)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, x, g);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic logic [15:0] cap(logic [15:0] v);
      return (v > 16'hFB00) ? 16'hFB00 : v;
   endfunction
   function automatic logic [74:0] frame(int k);
      case (k)
         0: return {PRIO_STD, PS_FUEL, 16'hFFFF, cap(fuel_econ_avg),
                    cap(fuel_econ_inst), fuel_rate};
         1: return {PRIO_STD, PS_AMB, 16'hFFFF, air_inlet_temp,
                    amb_air_temp, 16'hFFFF, baro_press};
         2: return {PRIO_STD, PS_INEX, 8'hFF, exh_gas_temp, filter_dpress,
                    air_inlet_press, manifold_temp, boost_press, 8'hFF};
         default: return {PRIO_PORT, 8'hA6 - 8'(k), port_temp[(k-3)*64+:64]};
      endcase
   endfunction
   task automatic shake;
      logic [31:0] r[4];
      foreach (r[i]) r[i] = $urandom;
      fuel_rate <= r[0][15:0];
      fuel_econ_inst <= r[0][31:16];
      // Top range so the cap is often hit
      fuel_econ_avg <= {5'h1F, r[1][10:0]};
      {air_inlet_temp, baro_press} <= r[1][31:16];
      {exh_gas_temp, amb_air_temp} <= r[2];
      {boost_press, manifold_temp, air_inlet_press, filter_dpress} <= r[3];
      for (int i = 0; i < 8; i++) port_temp[i*32+:32] <= $urandom;
   endtask
   ///////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(53099));
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (HALF) @(posedge core_clk);
      for (int k = 1; k <= 10; k++)
      begin
         // Half a period after an expiry everything has drained
         chk("pending", 64'd0, 64'(tx_pending));
         chk("valid", 64'd0, 64'(tx_valid));
         shake();
         @(posedge core_clk);
         m = {{4{k == 10}}, k % 5 == 0, k == 10, 1'b1};
         // due frames queued in index order
         for (int j = 0; j < 7; j++)
            if (m[j])
               exp_q.push_back(frame(j));
         // Pending word shows the due set two edges after expiry
         repeat (HALF + 2) @(posedge core_clk);
         chk("due", 64'(m), 64'(tx_pending));
         repeat (HALF - 3) @(posedge core_clk);
      end
      chk("frames left", 64'd0, 64'(exp_q.size()));
      chk("pending", 64'd0, 64'(tx_pending));
      wrap_up();
   end
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         errors++;
         wrap_up();
      end
      else if (rst_n && tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
         chk("prio", 64'(e[74:72]), 64'(tx_prio));
         chk("pgn", 64'(e[71:64]), 64'(tx_ps));
         chk("data", e[63:0], tx_data);
         chk("id", 64'(ID_EXP), 64'({tx_dp, tx_pf, tx_dlc}));
      end
   end
endmodule // test_j1939_engine_conditions_broadcast
